// file: design/cioa_alu.v
// Eight-bit add, subtract and AND with carry, half-carry and overflow.
// Purely combinational; the caller registers results and flags.
`timescale 1ns/10ps
`include "cioa_defines.vh"

module cioa_alu
(
  // Operands
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       cin,
  input  wire [1:0] kind,
  // Result and flags
  output reg  [7:0] r,
  output reg        c,
  output reg        h,
  output reg        v
);

  reg [8:0] full;
  reg [4:0] nib;

  always @*
  begin
    full = 9'h000;
    nib  = 5'h00;
    r    = 8'h00;
    c    = 1'b0;
    h    = 1'b0;
    v    = 1'b0;
    case (kind)
      `CIOA_ALU_ADD:
      begin
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r    = full[7:0];
        c    = full[8];
        h    = nib[4];
        v    = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
      end
      `CIOA_ALU_SUB:
      begin
        // Borrow out of the top bit is the carry flag
        full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        r    = full[7:0];
        c    = full[8];
        h    = nib[4];
        v    = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
      end
      `CIOA_ALU_AND:
      begin
        r = a & b;
      end
      default:
      begin
        r = 8'h00;
      end
    endcase
  end

endmodule // cioa_alu

// file: design/cioa_core.v
// Core slice: working registers, add/subtract/AND datapath and I/O access.
// Assumes peripherals on the same clock answer io_re one cycle later.
`timescale 1ns/10ps
`include "cioa_defines.vh"

module cioa_core
#(
  parameter NREG = 32
)
(
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Instruction command port
  input  wire       cmd_valid,
  input  wire [4:0] cmd_op,
  input  wire [4:0] cmd_rd,
  input  wire [4:0] cmd_rs,
  input  wire [7:0] cmd_k,
  input  wire [2:0] cmd_bit,
  output reg        cmd_busy_q,
  output reg        cmd_done_q,
  output reg        cmd_skip_q,
  output reg        cmd_err_q,
  // I/O bus toward peripheral registers
  output reg  [5:0] io_addr_q,
  output reg  [7:0] io_wdata_q,
  output reg  [7:0] io_wmask_q,
  output reg        io_we_q,
  output reg        io_re_q,
  input  wire [7:0] io_rdata,
  // Software register port
  input  wire [5:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  // Status flags
  output reg  [7:0] status_q
);

  // ****************************************
  // State and storage
  // ****************************************
  localparam S_IDLE = 2'h0;
  localparam S_WORD = 2'h1;
  localparam S_RDA  = 2'h2;
  localparam S_RDB  = 2'h3;

  reg [7:0] gpr [0:NREG-1];
  reg [1:0] state_q;
  reg [4:0] rd_q;
  reg [4:0] op_q;
  reg [2:0] bit_q;
  reg       carry_q;
  reg       lowz_q;
  integer   i;

  wire       start = cmd_valid & (state_q == S_IDLE);
  wire [4:0] rd_hi = rd_q + 5'h01;

  function is_word_sub;
    input [4:0] op;
    begin
      is_word_sub = (op == `CIOA_OP_SUBW);
    end
  endfunction

  // ****************************************
  // Operand selection
  // ****************************************
  reg  [7:0] alu_a;
  reg  [7:0] alu_b;
  reg        alu_cin;
  reg  [1:0] alu_kind;
  wire [7:0] alu_r;
  wire       alu_c;
  wire       alu_h;
  wire       alu_v;
  reg  [1:0] am_mode;
  wire [5:0] am_addr;
  wire       am_ok;

  always @*
  begin
    alu_a    = gpr[cmd_rd];
    alu_b    = gpr[cmd_rs];
    alu_cin  = 1'b0;
    alu_kind = `CIOA_ALU_ADD;
    am_mode  = `CIOA_AM_PORT;
    case (cmd_op)
      `CIOA_OP_ADC:   alu_cin = status_q[`CIOA_FC];
      `CIOA_OP_SUB:   alu_kind = `CIOA_ALU_SUB;
      `CIOA_OP_SUBK:
      begin
        alu_kind = `CIOA_ALU_SUB;
        alu_b    = cmd_k;
      end
      `CIOA_OP_SUBC:
      begin
        alu_kind = `CIOA_ALU_SUB;
        alu_cin  = status_q[`CIOA_FC];
      end
      `CIOA_OP_SBCK:
      begin
        alu_kind = `CIOA_ALU_SUB;
        alu_b    = cmd_k;
        alu_cin  = status_q[`CIOA_FC];
      end
      `CIOA_OP_AND:   alu_kind = `CIOA_ALU_AND;
      `CIOA_OP_ANDK:
      begin
        alu_kind = `CIOA_ALU_AND;
        alu_b    = cmd_k;
      end
      `CIOA_OP_ADDW:  alu_b = cmd_k & `CIOA_WORD_KMSK;
      `CIOA_OP_SUBW:
      begin
        alu_kind = `CIOA_ALU_SUB;
        alu_b    = cmd_k & `CIOA_WORD_KMSK;
      end
      `CIOA_OP_LOAD,
      `CIOA_OP_STORE: am_mode = `CIOA_AM_DATA;
      `CIOA_OP_SETB,
      `CIOA_OP_CLRB,
      `CIOA_OP_SKS,
      `CIOA_OP_SKC:   am_mode = `CIOA_AM_BIT;
      default:        alu_cin = 1'b0;
    endcase
    // Upper byte of a word operation ripples the low-byte carry
    if (state_q == S_WORD)
    begin
      alu_a    = gpr[rd_hi];
      alu_b    = 8'h00;
      alu_cin  = carry_q;
      alu_kind = is_word_sub(op_q) ? `CIOA_ALU_SUB : `CIOA_ALU_ADD;
    end
  end

  cioa_alu u_alu
  (
    .a    (alu_a),
    .b    (alu_b),
    .cin  (alu_cin),
    .kind (alu_kind),
    .r    (alu_r),
    .c    (alu_c),
    .h    (alu_h),
    .v    (alu_v)
  );

  cioa_ioaddr u_ioaddr
  (
    .raw     (cmd_k),
    .mode    (am_mode),
    .io_addr (am_addr),
    .ok      (am_ok)
  );

  // ****************************************
  // Sequencer, register file and I/O bus
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      for (i = 0; i < NREG; i = i + 1)
        gpr[i] <= 8'h00;
      state_q     <= S_IDLE;
      rd_q        <= 5'h00;
      op_q        <= 5'h00;
      bit_q       <= 3'h0;
      carry_q     <= 1'b0;
      lowz_q      <= 1'b0;
      cmd_busy_q  <= 1'b0;
      cmd_done_q  <= 1'b0;
      cmd_skip_q  <= 1'b0;
      cmd_err_q   <= 1'b0;
      io_addr_q   <= 6'h00;
      io_wdata_q  <= 8'h00;
      io_wmask_q  <= 8'h00;
      io_we_q     <= 1'b0;
      io_re_q     <= 1'b0;
      reg_rdata_q <= 8'h00;
      status_q    <= `CIOA_STATUS_RST;
    end
    else
    begin
      cmd_done_q <= 1'b0;
      cmd_skip_q <= 1'b0;
      cmd_err_q  <= 1'b0;
      io_we_q    <= 1'b0;
      io_re_q    <= 1'b0;

      // Software port; the instruction path below overrides it on a clash
      reg_rdata_q <= 8'h00;
      if (reg_rd)
      begin
        if (reg_addr <= `CIOA_RA_GPR_MAX)
          reg_rdata_q <= gpr[reg_addr[4:0]];
        else if (reg_addr == `CIOA_RA_STATUS)
          reg_rdata_q <= status_q;
        else if (reg_addr == `CIOA_RA_INFO)
          reg_rdata_q <= {5'h00, cmd_busy_q, state_q};
      end
      if (reg_wr)
      begin
        if (reg_addr <= `CIOA_RA_GPR_MAX)
          gpr[reg_addr[4:0]] <= reg_wdata;
        else if (reg_addr == `CIOA_RA_STATUS)
          status_q <= reg_wdata;
      end

      case (state_q)
        S_IDLE:
        begin
          if (start)
          begin
            rd_q  <= cmd_rd;
            op_q  <= cmd_op;
            bit_q <= cmd_bit;
            case (cmd_op)
              `CIOA_OP_ADD, `CIOA_OP_ADC, `CIOA_OP_SUB, `CIOA_OP_SUBK,
              `CIOA_OP_SUBC, `CIOA_OP_SBCK:
              begin
                gpr[cmd_rd]            <= alu_r;
                status_q[`CIOA_FC]     <= alu_c;
                status_q[`CIOA_FZ]     <= (alu_r == 8'h00);
                status_q[`CIOA_FN]     <= alu_r[7];
                status_q[`CIOA_FV]     <= alu_v;
                status_q[`CIOA_FH]     <= alu_h;
                cmd_done_q             <= 1'b1;
              end
              `CIOA_OP_AND, `CIOA_OP_ANDK:
              begin
                gpr[cmd_rd]        <= alu_r;
                status_q[`CIOA_FZ] <= (alu_r == 8'h00);
                status_q[`CIOA_FN] <= alu_r[7];
                status_q[`CIOA_FV] <= 1'b0;
                cmd_done_q         <= 1'b1;
              end
              `CIOA_OP_ADDW, `CIOA_OP_SUBW:
              begin
                gpr[cmd_rd] <= alu_r;
                carry_q     <= alu_c;
                lowz_q      <= (alu_r == 8'h00);
                cmd_busy_q  <= 1'b1;
                state_q     <= S_WORD;
              end
              `CIOA_OP_OUT, `CIOA_OP_STORE:
              begin
                // Full-byte write: ones here clear write-one flags
                if (am_ok)
                begin
                  io_addr_q  <= am_addr;
                  io_wdata_q <= gpr[cmd_rs];
                  io_wmask_q <= 8'hff;
                  io_we_q    <= 1'b1;
                end
                cmd_err_q  <= ~am_ok;
                cmd_done_q <= 1'b1;
              end
              `CIOA_OP_SETB, `CIOA_OP_CLRB:
              begin
                // Mask confines the write so neighbouring flags survive
                if (am_ok)
                begin
                  io_addr_q  <= am_addr;
                  io_wmask_q <= 8'h01 << cmd_bit;
                  io_wdata_q <= (cmd_op == `CIOA_OP_SETB) ? (8'h01 << cmd_bit)
                                                          : 8'h00;
                  io_we_q    <= 1'b1;
                end
                cmd_err_q  <= ~am_ok;
                cmd_done_q <= 1'b1;
              end
              `CIOA_OP_IN, `CIOA_OP_LOAD, `CIOA_OP_SKS, `CIOA_OP_SKC:
              begin
                if (am_ok)
                begin
                  io_addr_q  <= am_addr;
                  io_re_q    <= 1'b1;
                  cmd_busy_q <= 1'b1;
                  state_q    <= S_RDA;
                end
                else
                begin
                  cmd_err_q  <= 1'b1;
                  cmd_done_q <= 1'b1;
                end
              end
              default:
              begin
                cmd_err_q  <= 1'b1;
                cmd_done_q <= 1'b1;
              end
            endcase
          end
        end
        S_WORD:
        begin
          gpr[rd_hi]         <= alu_r;
          status_q[`CIOA_FZ] <= lowz_q & (alu_r == 8'h00);
          status_q[`CIOA_FN] <= alu_r[7];
          if (is_word_sub(op_q))
          begin
            status_q[`CIOA_FV] <= alu_a[7] & ~alu_r[7];
            status_q[`CIOA_FC] <= alu_r[7] & ~alu_a[7];
            status_q[`CIOA_FS] <= alu_r[7] ^ (alu_a[7] & ~alu_r[7]);
          end
          else
          begin
            status_q[`CIOA_FV] <= ~alu_a[7] & alu_r[7];
            status_q[`CIOA_FC] <= ~alu_r[7] & alu_a[7];
            status_q[`CIOA_FS] <= alu_r[7] ^ (~alu_a[7] & alu_r[7]);
          end
          cmd_busy_q <= 1'b0;
          cmd_done_q <= 1'b1;
          state_q    <= S_IDLE;
        end
        S_RDA:
        begin
          // Peripheral presents read data in the cycle after io_re
          state_q <= S_RDB;
        end
        S_RDB:
        begin
          if (op_q == `CIOA_OP_SKS)
            cmd_skip_q <= io_rdata[bit_q];
          else if (op_q == `CIOA_OP_SKC)
            cmd_skip_q <= ~io_rdata[bit_q];
          else
            gpr[rd_q] <= io_rdata;
          cmd_busy_q <= 1'b0;
          cmd_done_q <= 1'b1;
          state_q    <= S_IDLE;
        end
        default:
        begin
          state_q    <= S_IDLE;
          cmd_busy_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // cioa_core

// file: design/cioa_ioaddr.v
// Maps a raw command address onto the 64-entry I/O space and checks range.
// Combinational; port, data-space and bit-access forms are handled.
`timescale 1ns/10ps
`include "cioa_defines.vh"

module cioa_ioaddr
(
  // Request
  input  wire [7:0] raw,
  input  wire [1:0] mode,
  // Decoded address
  output reg  [5:0] io_addr,
  output reg        ok
);

  reg [7:0] off;

  always @*
  begin
    off     = raw - `CIOA_DS_OFS;
    io_addr = raw[5:0];
    ok      = 1'b0;
    case (mode)
      `CIOA_AM_PORT:
      begin
        ok = (raw <= `CIOA_PORT_MAX);
      end
      `CIOA_AM_DATA:
      begin
        io_addr = off[5:0];
        ok      = (raw >= `CIOA_DS_OFS) && (raw <= `CIOA_DS_MAX);
      end
      `CIOA_AM_BIT:
      begin
        ok = (raw <= `CIOA_BIT_MAX);
      end
      default:
      begin
        ok = 1'b0;
      end
    endcase
  end

endmodule // cioa_ioaddr

// file: dv/cioa_core_sva.sv
// Checker of the core slice ports: command timing, I/O addressing, flags.
// Assumes it is bound onto cioa_core and sees only its ports.
`timescale 1ns/10ps
`include "cioa_defines.vh"

module cioa_core_sva
(
  // Clock and reset
  input wire       clk,
  input wire       rst,
  // Command port
  input wire       cmd_valid,
  input wire [4:0] cmd_op,
  input wire [7:0] cmd_k,
  input wire [2:0] cmd_bit,
  input wire       cmd_busy_q,
  input wire       cmd_done_q,
  input wire       cmd_skip_q,
  input wire       cmd_err_q,
  // I/O bus and flags
  input wire [5:0] io_addr_q,
  input wire [7:0] io_wdata_q,
  input wire [7:0] io_wmask_q,
  input wire       io_we_q,
  input wire       io_re_q,
  input wire [7:0] io_rdata,
  input wire [7:0] status_q
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire      take = cmd_valid && !cmd_busy_q;
  wire      bop  = cmd_op == `CIOA_OP_SETB || cmd_op == `CIOA_OP_CLRB;
  wire      dsp  = cmd_op == `CIOA_OP_LOAD || cmd_op == `CIOA_OP_STORE;
  wire      wop  = cmd_op == `CIOA_OP_ADDW || cmd_op == `CIOA_OP_SUBW;
  wire      aop  = cmd_op == `CIOA_OP_AND || cmd_op == `CIOA_OP_ANDK;
  reg [2:0] bit_h;
  // Commands are never taken while busy, so this holds for the whole command
  always @(posedge clk)
  begin
    if (take)
      bit_h <= cmd_bit;
  end
  a_port_range: assert property (take && cmd_op == `CIOA_OP_IN && cmd_k > 8'h3f
    |=> cmd_err_q && !io_re_q) else $error("port read past range not refused");
  a_out_mask: assert property (take && cmd_op == `CIOA_OP_OUT && cmd_k <= 8'h3f
    |=> io_we_q && io_wmask_q == 8'hff && io_addr_q == $past(cmd_k[5:0]))
    else $error("port write wrong");
  a_ds_offset: assert property (take && dsp && cmd_k >= 8'h20 && cmd_k <= 8'h5f
    |=> (io_we_q || io_re_q) && io_addr_q == $past(cmd_k[5:0]) - 6'h20)
    else $error("data space offset wrong");
  a_bit_range: assert property (take && bop && cmd_k > 8'h1f
    |=> cmd_err_q && !io_we_q) else $error("bit op past range not refused");
  a_bit_only: assert property (take && bop && cmd_k <= 8'h1f
    |=> io_we_q && io_wmask_q == (8'h01 << $past(cmd_bit)) && io_wdata_q ==
    (($past(cmd_op) == `CIOA_OP_SETB) ? io_wmask_q : 8'h00)) else $error("bit write wrong");
  a_skip_set: assert property (take && cmd_op == `CIOA_OP_SKS && cmd_k <= 8'h1f
    |=> io_re_q ##2 cmd_done_q && cmd_skip_q == $past(io_rdata[bit_h]))
    else $error("skip on set wrong");
  a_skip_clr: assert property (take && cmd_op == `CIOA_OP_SKC && cmd_k <= 8'h1f
    |=> io_re_q ##2 cmd_done_q && cmd_skip_q != $past(io_rdata[bit_h]))
    else $error("skip on clear wrong");
  a_byte_one: assert property (take && cmd_op <= `CIOA_OP_ANDK
    |=> cmd_done_q && !cmd_busy_q && !cmd_err_q) else $error("byte op not one cycle");
  a_word_two: assert property (take && wop
    |=> cmd_busy_q && !cmd_done_q ##1 cmd_done_q && !cmd_busy_q)
    else $error("word op not two cycles");
  a_and_carry: assert property (take && aop
    |=> status_q[0] == $past(status_q[0]) && !status_q[3]) else $error("AND flags wrong");
  c_skip: cover property (take && cmd_op == `CIOA_OP_SKS ##3 cmd_skip_q);
  c_word: cover property (take && cmd_op == `CIOA_OP_ADDW ##2 cmd_done_q);
  c_err: cover property (take && bop ##1 cmd_err_q);
endmodule // cioa_core_sva

bind cioa_core cioa_core_sva chk_u (.clk, .rst, .cmd_valid, .cmd_op, .cmd_k, .cmd_bit,
  .cmd_busy_q, .cmd_done_q, .cmd_skip_q, .cmd_err_q, .io_addr_q, .io_wdata_q,
  .io_wmask_q, .io_we_q, .io_re_q, .io_rdata, .status_q);

// file: dv/cioa_periph_model.sv
// Model of the peripheral registers in the 64-entry I/O space.
// Assumes the core's clock; one register holds write-one-to-clear flags.
`timescale 1ns/10ps

module cioa_periph_model
#(
  parameter FLAG_ADDR = 6'h0e,
  parameter W1C_MASK  = 8'he0
)
(
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // I/O bus from the core
  input  wire [5:0] io_addr_q,
  input  wire [7:0] io_wdata_q,
  input  wire [7:0] io_wmask_q,
  input  wire       io_we_q,
  input  wire       io_re_q,
  output reg  [7:0] io_rdata,
  // Flag events from the bench
  input  wire [7:0] flag_set
);
  // ****************************************
  // Register array
  // ****************************************
  reg  [7:0] regs_q [0:63];
  wire [7:0] w1c = (io_addr_q == FLAG_ADDR) ? W1C_MASK : 8'h00;
  wire [7:0] wm  = io_we_q ? io_wmask_q : 8'h00;
  integer    i;
  always @(posedge clk)
  begin
    if (rst)
    begin
      for (i = 0; i < 64; i = i + 1)
        regs_q[i] <= 8'h00;
      io_rdata <= 8'h00;
    end
    else
    begin
      // Masked bits only; a one clears a flag bit
      regs_q[io_addr_q] <= ((regs_q[io_addr_q] & ~(wm & ~w1c)) | (io_wdata_q & wm & ~w1c))
        & ~(io_wdata_q & wm & w1c);
      if (flag_set != 8'h00)
        regs_q[FLAG_ADDR] <= regs_q[FLAG_ADDR] | flag_set;
      // Bus released between reads: drive the inverted last value each cycle
      io_rdata <= io_re_q ? regs_q[io_addr_q] : ~io_rdata;
    end
  end
endmodule // cioa_periph_model

// file: dv/tb_top.sv
// Self-checking bench of the core slice with a peripheral register model.
// Assumes the checker is bound by its own file.
`timescale 1ns/10ps
`include "cioa_defines.vh"

module tb_top;
  reg        clk, rst, cmd_valid, reg_wr, reg_rd, err_v, skip_v;
  reg  [4:0] cmd_op, cmd_rd, cmd_rs;
  reg  [7:0] cmd_k, reg_wdata, flag_set, rd_v, cyc_v;
  reg  [2:0] cmd_bit;
  reg  [5:0] reg_addr;
  wire       cmd_busy_q, cmd_done_q, cmd_skip_q, cmd_err_q, io_we_q, io_re_q;
  wire [5:0] io_addr_q;
  wire [7:0] io_wdata_q, io_wmask_q, io_rdata, reg_rdata_q, status_q;
  integer    miscompares, checked;

  cioa_core dut_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_rd(cmd_rd), .cmd_rs(cmd_rs), .cmd_k(cmd_k), .cmd_bit(cmd_bit),
    .cmd_busy_q(cmd_busy_q), .cmd_done_q(cmd_done_q), .cmd_skip_q(cmd_skip_q),
    .cmd_err_q(cmd_err_q), .io_addr_q(io_addr_q), .io_wdata_q(io_wdata_q),
    .io_wmask_q(io_wmask_q), .io_we_q(io_we_q), .io_re_q(io_re_q), .io_rdata(io_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .status_q(status_q));
  cioa_periph_model peer_u (.clk(clk), .rst(rst), .io_addr_q(io_addr_q),
    .io_wdata_q(io_wdata_q), .io_wmask_q(io_wmask_q), .io_we_q(io_we_q),
    .io_re_q(io_re_q), .io_rdata(io_rdata), .flag_set(flag_set));

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string what, input [7:0] exp, input [7:0] got);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task end_sim;
  begin
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task reg_write(input [5:0] a, input [7:0] d);
  begin
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task reg_read(input [5:0] a);
  begin
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata_q;
  end
  endtask
  task cmd(input [4:0] op, input [4:0] rd, input [4:0] rs, input [7:0] k, input [2:0] b);
    integer n;
  begin
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_rd <= rd;
    cmd_rs <= rs;
    cmd_k <= k;
    cmd_bit <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    n = 0;
    while (cmd_done_q !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    err_v = cmd_err_q;
    skip_v = cmd_skip_q;
    cyc_v = 8'h01 + n[7:0];
    chk("done", 8'h01, {7'h00, cmd_done_q});
    chk("busy end", 8'h00, {7'h00, cmd_busy_q});
  end
  endtask
  task alu_case(input [4:0] op, input [7:0] a, input [7:0] b, input ci, input [7:0] er,
    input [7:0] ef);
  begin
    reg_write(6'h01, a);
    reg_write(6'h02, b);
    reg_write(6'h20, {7'h00, ci});
    cmd(op, 5'h01, 5'h02, b, 3'h0);
    chk("alu cycles", 8'h01, cyc_v);
    reg_read(6'h01);
    chk("alu result", er, rd_v);
    reg_read(6'h20);
    chk("alu flags", ef, rd_v);
    chk("flag port", ef, status_q);
  end
  endtask
  task word_case(input [4:0] op, input [7:0] lo, input [7:0] hi, input [7:0] k,
    input [7:0] el, input [7:0] eh, input [7:0] ef);
  begin
    reg_write(6'h18, lo);
    reg_write(6'h19, hi);
    reg_write(6'h20, 8'h00);
    cmd(op, 5'h18, 5'h00, k, 3'h0);
    chk("word cycles", 8'h02, cyc_v);
    reg_read(6'h18);
    chk("word low", el, rd_v);
    reg_read(6'h19);
    chk("word high", eh, rd_v);
    reg_read(6'h20);
    chk("word flags", ef, rd_v);
    chk("word flag port", ef, status_q);
  end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
  begin
    reg_read(6'h20);
    chk("status reset", 8'h00, rd_v);
    reg_read(6'h3f);
    chk("unmapped read", 8'h00, rd_v);
    reg_read(6'h21);
    chk("info idle", 8'h00, rd_v);
    $display("test reset done");
  end
  endtask
  task t_alu;
  begin
    alu_case(`CIOA_OP_ADD, 8'h7f, 8'h01, 1'b0, 8'h80, 8'h2c);
    alu_case(`CIOA_OP_ADC, 8'hff, 8'h00, 1'b1, 8'h00, 8'h23);
    alu_case(`CIOA_OP_SUB, 8'h10, 8'h01, 1'b0, 8'h0f, 8'h20);
    alu_case(`CIOA_OP_SUBK, 8'h00, 8'h01, 1'b0, 8'hff, 8'h25);
    alu_case(`CIOA_OP_SUBC, 8'h05, 8'h04, 1'b1, 8'h00, 8'h02);
    alu_case(`CIOA_OP_SBCK, 8'h80, 8'h01, 1'b0, 8'h7f, 8'h28);
    alu_case(`CIOA_OP_AND, 8'hf0, 8'h0f, 1'b1, 8'h00, 8'h03);
    alu_case(`CIOA_OP_ANDK, 8'h81, 8'h80, 1'b0, 8'h80, 8'h04);
    word_case(`CIOA_OP_ADDW, 8'hff, 8'h7f, 8'h01, 8'h00, 8'h80, 8'h0c);
    word_case(`CIOA_OP_ADDW, 8'hff, 8'h00, 8'h3f, 8'h3e, 8'h01, 8'h00);
    word_case(`CIOA_OP_SUBW, 8'h00, 8'h00, 8'h01, 8'hff, 8'hff, 8'h15);
    $display("test arithmetic done");
  end
  endtask
  task t_io;
  begin
    reg_write(6'h01, 8'h5a);
    cmd(`CIOA_OP_OUT, 5'h00, 5'h01, 8'h3f, 3'h0);
    cmd(`CIOA_OP_IN, 5'h03, 5'h00, 8'h3f, 3'h0);
    chk("port write", 8'h5a, peer_u.regs_q[63]);
    reg_read(6'h03);
    chk("port read", 8'h5a, rd_v);
    cmd(`CIOA_OP_IN, 5'h03, 5'h00, 8'h40, 3'h0);
    chk("port range", 8'h01, {7'h00, err_v});
    cmd(`CIOA_OP_STORE, 5'h00, 5'h01, 8'h32, 3'h0);
    cmd(`CIOA_OP_LOAD, 5'h04, 5'h00, 8'h32, 3'h0);
    chk("store place", 8'h5a, peer_u.regs_q[18]);
    reg_read(6'h04);
    chk("load data", 8'h5a, rd_v);
    cmd(`CIOA_OP_STORE, 5'h00, 5'h01, 8'h1f, 3'h0);
    chk("data range", 8'h01, {7'h00, err_v});
    cmd(`CIOA_OP_OUT, 5'h00, 5'h05, 8'h0e, 3'h0);
    @(posedge clk);
    flag_set <= 8'he0;
    @(posedge clk);
    flag_set <= 8'h00;
    cmd(`CIOA_OP_SETB, 5'h00, 5'h00, 8'h0e, 3'h0);
    cmd(`CIOA_OP_SKS, 5'h00, 5'h00, 8'h0e, 3'h5);
    chk("skip set", 8'h01, {7'h00, skip_v});
    chk("flags kept", 8'he1, peer_u.regs_q[14]);
    cmd(`CIOA_OP_CLRB, 5'h00, 5'h00, 8'h0e, 3'h0);
    cmd(`CIOA_OP_SKC, 5'h00, 5'h00, 8'h0e, 3'h0);
    chk("skip clear", 8'h01, {7'h00, skip_v});
    reg_write(6'h05, 8'h80);
    cmd(`CIOA_OP_OUT, 5'h00, 5'h05, 8'h0e, 3'h0);
    cmd(`CIOA_OP_SKC, 5'h00, 5'h00, 8'h0e, 3'h6);
    chk("no skip", 8'h00, {7'h00, skip_v});
    chk("flag cleared", 8'h60, peer_u.regs_q[14]);
    cmd(`CIOA_OP_SETB, 5'h00, 5'h00, 8'h20, 3'h0);
    chk("bit range", 8'h01, {7'h00, err_v});
    $display("test io done");
  end
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // About two hundred cycles are expected; a hundred times that means a hang
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    end_sim;
  end
  initial
  begin
    miscompares = 0;
    checked = 0;
    {rst, cmd_valid, reg_wr, reg_rd} = 4'hf ^ 4'h7;
    {cmd_op, cmd_rd, cmd_rs, cmd_k, cmd_bit} = 26'h0;
    {reg_wdata, flag_set, reg_addr} = 22'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_alu;
    t_io;
    end_sim;
  end
endmodule // tb_top

// file: shared/cioa_defines.vh
// Constants for the core I/O access and arithmetic block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef CIOA_DEFINES_VH
`define CIOA_DEFINES_VH

// ****************************************
// Command codes
// ****************************************
`define CIOA_OP_ADD    5'h00
`define CIOA_OP_ADC    5'h01
`define CIOA_OP_SUB    5'h02
`define CIOA_OP_SUBK   5'h03
`define CIOA_OP_SUBC   5'h04
`define CIOA_OP_SBCK   5'h05
`define CIOA_OP_AND    5'h06
`define CIOA_OP_ANDK   5'h07
`define CIOA_OP_ADDW   5'h08
`define CIOA_OP_SUBW   5'h09
`define CIOA_OP_IN     5'h0a
`define CIOA_OP_OUT    5'h0b
`define CIOA_OP_LOAD   5'h0c
`define CIOA_OP_STORE  5'h0d
`define CIOA_OP_SETB   5'h0e
`define CIOA_OP_CLRB   5'h0f
`define CIOA_OP_SKS    5'h10
`define CIOA_OP_SKC    5'h11

// ****************************************
// Arithmetic kinds
// ****************************************
`define CIOA_ALU_ADD   2'h0
`define CIOA_ALU_SUB   2'h1
`define CIOA_ALU_AND   2'h2

// ****************************************
// Address decode modes and limits
// ****************************************
`define CIOA_AM_PORT   2'h0
`define CIOA_AM_DATA   2'h1
`define CIOA_AM_BIT    2'h2
`define CIOA_PORT_MAX  8'h3f
`define CIOA_BIT_MAX   8'h1f
`define CIOA_DS_OFS    8'h20
`define CIOA_DS_MAX    8'h5f
`define CIOA_WORD_KMSK 8'h3f

// ****************************************
// Status flag positions
// ****************************************
`define CIOA_FC        0
`define CIOA_FZ        1
`define CIOA_FN        2
`define CIOA_FV        3
`define CIOA_FS        4
`define CIOA_FH        5

// ****************************************
// Software register port map
// ****************************************
`define CIOA_RA_GPR_MAX 6'h1f
`define CIOA_RA_STATUS  6'h20
`define CIOA_RA_INFO    6'h21
`define CIOA_STATUS_RST 8'h00

`endif
